// File: design/lbsm_line_buffer_monitor.sv
// Line control and buffer control sequencing with data-check and attention lamps.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1: Buffer sits in its initial state while the line transmits the message.
// RL2: Parity error on a character received in message-receive lights data check.
// RL3: Parity error on a character sent in message-transmit lights data check.
// RL4: Negative reply after the second transmission moves to failure and lights data check.
// RL5: Parity error in keyboard entry or buffer print states lights data check.
// RL6: Passing from one-second delay to attention lights the attention lamp.
// RL7: Entering the one-second delay starts a one-second timer; expiry moves on.
// RL8: Entering idle wait starts a fifteen-second timer; expiry moves on.
// RL9: A flag marks the first transmission of the message.
// RL10: A flag marks the second transmission; no further automatic retransmission.
// RL11: Parity error on the first received message character is flagged.
// RL12: End of reception classes the message as good or bad by parity.
// RL13: Address match is own address, or group or all-stations master.
// RL14: Open print feedback contacts mean magnets released and advance printing.
// RL15: Each line state is classed receiving, transmitting or intermediate.
// RL16: Line controller has sixteen states, buffer eight, shown on indicators.
// RL17: Buffer state four shows a message ready for the processor.
// RL18: Receive status is true only when the terminal can accept a message.
// RL19: Both lamps stay lit until the reset key, then clear.
module lbsm_line_buffer_monitor
  import lbsm_pkg::*;
#(
  parameter int ONE_SECOND_CYCLES_P     = ONE_SECOND_CYCLES,
  parameter int FIFTEEN_SECOND_CYCLES_P = FIFTEEN_SECOND_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  rx_char_valid,
  input  wire logic                  rx_parity_error,
  input  wire logic                  rx_is_poll,
  input  wire logic                  rx_is_own_address,
  input  wire logic                  rx_is_start,
  input  wire logic                  rx_is_end,
  input  wire logic                  rx_is_ack,
  input  wire logic                  rx_is_nak,
  input  wire logic                  rx_is_idle,
  input  wire logic                  tx_char_done,
  input  wire logic                  tx_parity_error,
  input  wire logic                  tx_last_char,
  input  wire logic                  group_master,
  input  wire logic                  all_stations_master,
  input  wire logic                  receive_ready,
  input  wire logic                  kbd_strobe,
  input  wire logic                  kbd_parity_error,
  input  wire logic                  buffer_parity_error,
  input  wire logic                  enter_key,
  input  wire logic                  send_key,
  input  wire logic                  clear_key,
  input  wire logic                  print_key,
  input  wire logic                  print_feedback_open,
  input  wire logic                  print_last_char,
  input  wire logic                  reset_key,
  output logic [LINE_IND_W-1:0]      line_indicator,
  output logic [BUF_IND_W-1:0]       buffer_indicator,
  output logic [1:0]                 line_class,
  output logic                       transmit_enable,
  output logic                       address_match,
  output logic                       receive_status,
  output logic                       data_check_lamp,
  output logic                       attention_lamp,
  output logic                       first_transmission,
  output logic                       second_transmission,
  output logic                       first_char_parity_fault,
  output logic                       receive_error_flag,
  output logic                       rx_message_ok,
  output logic                       rx_message_bad,
  output logic                       print_char_strobe
);

  lbsm_line_state_t line_q, line_d;
  lbsm_buf_state_t  buf_q, buf_d;
  logic             msg_pending_q;
  logic             first_char_pending_q;
  logic             boot_q;
  logic             one_start, one_busy, one_expired;
  logic             fif_start, fif_busy, fif_expired;
  logic             dc_set, att_set, buf_printing, rx_done_ok;

  // ----------------------------------------------------------------
  // Conditions
  // ----------------------------------------------------------------
  assign address_match  = rx_is_own_address | group_master | all_stations_master; // RL13
  assign receive_status = receive_ready & (buf_q == BS_INITIAL) & ~msg_pending_q; // RL18
  assign buf_printing   = (buf_q == BS_PRINT_FIRST) | (buf_q == BS_PRINT_WAIT)
                        | (buf_q == BS_PRINT_LAST);
  assign transmit_enable = (line_q == LS_TRANSMIT_MESSAGE);

  // ----------------------------------------------------------------
  // Delay timers
  // ----------------------------------------------------------------
  assign one_start = (line_d == LS_ONE_SECOND_DELAY) && (line_q != LS_ONE_SECOND_DELAY); // RL7
  assign fif_start = ((line_d == LS_IDLE_WAIT) && (line_q != LS_IDLE_WAIT)) || !boot_q; // RL8

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_q <= 1'h0;
    end else begin
      boot_q <= 1'h1;
    end
  end

  lbsm_delay_timer #(.COUNT(ONE_SECOND_CYCLES_P)) u_one_second_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (one_start),
    .busy    (one_busy),
    .expired (one_expired)
  );

  lbsm_delay_timer #(.COUNT(FIFTEEN_SECOND_CYCLES_P)) u_fifteen_second_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (fif_start),
    .busy    (fif_busy),
    .expired (fif_expired)
  );

  // ----------------------------------------------------------------
  // Line controller
  // ----------------------------------------------------------------
  always_comb begin
    line_d = line_q;
    case (line_q)
      LS_IDLE_WAIT: begin
        if (rx_char_valid && rx_is_poll) begin
          line_d = LS_ADDRESS_WAIT;
        end else if (fif_expired) begin // RL8
          line_d = LS_ONE_SECOND_DELAY;
        end
      end
      LS_ADDRESS_WAIT: begin
        if (rx_char_valid) begin
          line_d = address_match ? LS_STATUS_CHECK : LS_IDLE_WAIT; // RL13
        end
      end
      LS_STATUS_CHECK: begin
        if (msg_pending_q) begin
          line_d = LS_TRANSMIT_MESSAGE;
        end else if (receive_status) begin // RL18
          line_d = LS_PRE_RECEIVE;
        end else begin
          line_d = LS_IDLE_WAIT;
        end
      end
      LS_PRE_RECEIVE: begin
        if (rx_char_valid && rx_is_start) begin
          line_d = LS_RECEIVE_MESSAGE;
        end
      end
      LS_RECEIVE_MESSAGE: begin
        if (rx_char_valid && rx_is_end) begin
          line_d = LS_RECEIVE_DONE;
        end
      end
      LS_RECEIVE_DONE:     line_d = LS_IDLE_WAIT;
      LS_TRANSMIT_MESSAGE: begin
        if (tx_char_done && tx_last_char) begin
          line_d = LS_RETRY_PENDING;
        end
      end
      LS_RETRY_PENDING: begin
        if (rx_char_valid && rx_is_ack) begin
          line_d = LS_IDLE_WAIT;
        end else if (rx_char_valid && rx_is_nak) begin
          line_d = second_transmission ? LS_FAILURE : LS_TRANSMIT_MESSAGE; // RL10
        end
      end
      LS_FAILURE: begin
        if (reset_key) begin
          line_d = LS_IDLE_WAIT;
        end
      end
      LS_ONE_SECOND_DELAY: begin
        if (one_expired) begin // RL7
          line_d = LS_ATTENTION;
        end
      end
      LS_ATTENTION: begin
        if ((rx_char_valid && rx_is_idle) || reset_key) begin
          line_d = LS_IDLE_WAIT;
        end
      end
      default: line_d = LS_IDLE_WAIT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_q <= LS_IDLE_WAIT;
    end else begin
      line_q <= line_d;
    end
  end

  // Indicator decode and line class.
  always_comb begin
    line_indicator   = '0;
    buffer_indicator = '0;
    for (int i = 0; i < LINE_STATES; i++) begin
      if (line_q[i]) begin
        line_indicator = LINE_IND_W'(i); // RL16
      end
    end
    for (int j = 0; j < BUF_STATES; j++) begin
      if (buf_q[j]) begin
        buffer_indicator = BUF_IND_W'(j); // RL16
      end
    end
    case (line_q)
      LS_PRE_RECEIVE, LS_RECEIVE_MESSAGE: line_class = LCLASS_RECEIVING; // RL15
      LS_TRANSMIT_MESSAGE:                line_class = LCLASS_TRANSMITTING; // RL15
      default:                            line_class = LCLASS_INTERMEDIATE; // RL15
    endcase
  end

  // ----------------------------------------------------------------
  // Transmission tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_transmission  <= 1'h0;
      second_transmission <= 1'h0;
    end else if (line_q == LS_STATUS_CHECK && line_d == LS_TRANSMIT_MESSAGE) begin
      first_transmission  <= 1'h1; // RL9
      second_transmission <= 1'h0;
    end else if (line_q == LS_RETRY_PENDING && line_d == LS_TRANSMIT_MESSAGE) begin
      first_transmission  <= 1'h0;
      second_transmission <= 1'h1; // RL10
    end else if (line_d == LS_IDLE_WAIT) begin
      first_transmission  <= 1'h0;
      second_transmission <= 1'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_pending_q <= 1'h0;
    end else if (buf_q == BS_ENTRY && send_key) begin
      msg_pending_q <= 1'h1;
    end else if ((line_q == LS_RETRY_PENDING && line_d == LS_IDLE_WAIT)
                 || line_d == LS_FAILURE || (buf_q == BS_READY && clear_key)) begin
      msg_pending_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Reception checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_char_pending_q    <= 1'h0;
      first_char_parity_fault <= 1'h0;
      receive_error_flag      <= 1'h0;
    end else if (line_q == LS_PRE_RECEIVE && line_d == LS_RECEIVE_MESSAGE) begin
      first_char_pending_q    <= 1'h1;
      first_char_parity_fault <= 1'h0;
      receive_error_flag      <= 1'h0;
    end else if (line_q == LS_RECEIVE_MESSAGE && rx_char_valid) begin
      first_char_pending_q <= 1'h0;
      if (first_char_pending_q && rx_parity_error) begin
        first_char_parity_fault <= 1'h1; // RL11
      end
      if (rx_parity_error) begin
        receive_error_flag <= 1'h1; // RL12
      end
    end
  end

  assign rx_done_ok = (line_q == LS_RECEIVE_DONE) && !receive_error_flag;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_message_ok  <= 1'h0;
      rx_message_bad <= 1'h0;
    end else begin
      rx_message_ok  <= rx_done_ok; // RL12
      rx_message_bad <= (line_q == LS_RECEIVE_DONE) && receive_error_flag; // RL12
    end
  end

  // ----------------------------------------------------------------
  // Buffer controller
  // ----------------------------------------------------------------
  always_comb begin
    buf_d = buf_q;
    case (buf_q)
      BS_INITIAL: begin
        if (enter_key) begin
          buf_d = BS_ENTRY;
        end else if (rx_done_ok) begin
          buf_d = BS_PRINT_FIRST;
        end
      end
      BS_ENTRY: begin
        if (send_key) begin
          buf_d = BS_READY; // RL17
        end else if (clear_key) begin
          buf_d = BS_INITIAL;
        end
      end
      BS_READY: begin
        if (clear_key) begin
          buf_d = BS_ENTRY;
        end else if (print_key) begin
          buf_d = BS_PRINT_FIRST;
        end
      end
      BS_PRINT_FIRST: buf_d = BS_PRINT_WAIT;
      BS_PRINT_WAIT: begin
        if (print_feedback_open) begin // RL14
          buf_d = print_last_char ? BS_PRINT_LAST : BS_PRINT_FIRST;
        end
      end
      BS_PRINT_LAST:  buf_d = msg_pending_q ? BS_READY : BS_INITIAL;
      default:        buf_d = BS_INITIAL;
    endcase
    if (line_d == LS_TRANSMIT_MESSAGE) begin
      buf_d = BS_INITIAL; // RL1
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_q             <= BS_INITIAL;
      print_char_strobe <= 1'h0;
    end else begin
      buf_q             <= buf_d;
      print_char_strobe <= (buf_q == BS_PRINT_FIRST);
    end
  end

  // ----------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------
  assign dc_set = (line_q == LS_RECEIVE_MESSAGE && rx_char_valid && rx_parity_error) // RL2
                | (line_q == LS_TRANSMIT_MESSAGE && tx_char_done && tx_parity_error) // RL3
                | (line_q == LS_RETRY_PENDING && line_d == LS_FAILURE) // RL4
                | (buf_q == BS_ENTRY && kbd_strobe && kbd_parity_error) // RL5
                | (buf_printing && buffer_parity_error); // RL5
  assign att_set = (line_q == LS_ONE_SECOND_DELAY) && (line_d == LS_ATTENTION); // RL6

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_check_lamp <= LAMP_OFF;
      attention_lamp  <= LAMP_OFF;
    end else begin
      data_check_lamp <= dc_set | (data_check_lamp & ~reset_key); // RL19
      attention_lamp  <= att_set | (attention_lamp & ~reset_key); // RL19
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tx_buffer_initial;
    (line_q == LS_TRANSMIT_MESSAGE) |-> (buf_q == BS_INITIAL);
  endproperty
  a_tx_buffer_initial: assert property (p_tx_buffer_initial) // RL1
    else $error("Buffer not initial during transmit.");

  property p_rx_parity_lamp;
    (line_q == LS_RECEIVE_MESSAGE && rx_char_valid && rx_parity_error)
      |=> (data_check_lamp && receive_error_flag);
  endproperty
  a_rx_parity_lamp: assert property (p_rx_parity_lamp) // RL2
    else $error("Receive parity error did not light data check.");

  property p_tx_parity_lamp;
    (line_q == LS_TRANSMIT_MESSAGE && tx_char_done && tx_parity_error) |=> data_check_lamp;
  endproperty
  a_tx_parity_lamp: assert property (p_tx_parity_lamp) // RL3
    else $error("Transmit parity error did not light data check.");

  property p_second_nak_fails;
    (line_q == LS_RETRY_PENDING && rx_char_valid && !rx_is_ack && rx_is_nak
      && second_transmission) |=> (line_q == LS_FAILURE && data_check_lamp);
  endproperty
  a_second_nak_fails: assert property (p_second_nak_fails) // RL4
    else $error("Negative reply after second transmission did not fail.");

  property p_entry_parity_lamp;
    (buf_q == BS_ENTRY && kbd_strobe && kbd_parity_error) |=> data_check_lamp;
  endproperty
  a_entry_parity_lamp: assert property (p_entry_parity_lamp) // RL5
    else $error("Entry parity error did not light data check.");

  property p_attention_lamp;
    (line_q == LS_ONE_SECOND_DELAY && one_expired)
      |=> (line_q == LS_ATTENTION && attention_lamp);
  endproperty
  a_attention_lamp: assert property (p_attention_lamp) // RL6
    else $error("Attention transition did not light attention lamp.");

  property p_one_second_start;
    (line_q != LS_ONE_SECOND_DELAY) ##1 (line_q == LS_ONE_SECOND_DELAY) |-> one_busy;
  endproperty
  a_one_second_start: assert property (p_one_second_start) // RL7
    else $error("One-second delay not running on entry.");

  property p_fifteen_second_start;
    (line_q != LS_IDLE_WAIT) ##1 (line_q == LS_IDLE_WAIT) |-> fif_busy;
  endproperty
  a_fifteen_second_start: assert property (p_fifteen_second_start) // RL8
    else $error("Fifteen-second delay not running on idle entry.");

  property p_first_tx_flag;
    (line_q == LS_STATUS_CHECK && msg_pending_q)
      |=> (first_transmission && !second_transmission) [*2];
  endproperty
  a_first_tx_flag: assert property (p_first_tx_flag) // RL9
    else $error("First transmission not flagged.");

  property p_lamp_clear;
    (reset_key && !dc_set && !att_set) |=> (!data_check_lamp && !attention_lamp);
  endproperty
  a_lamp_clear: assert property (p_lamp_clear) // RL19
    else $error("Lamps did not clear on reset key.");

  c_retransmit: cover property ((line_q == LS_RETRY_PENDING) ##1
                                (line_q == LS_TRANSMIT_MESSAGE && second_transmission));
  c_failure:    cover property ((line_q == LS_RETRY_PENDING) ##1 (line_q == LS_FAILURE));
  c_attention:  cover property ((line_q == LS_ONE_SECOND_DELAY) ##1 (line_q == LS_ATTENTION));
  c_rx_bad:     cover property (rx_message_bad);

endmodule
`default_nettype wire

// File: shared/lbsm_pkg.sv
// Constants, state encodings and timing for the line and buffer state monitor.
package lbsm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ          = 100_000_000;
  localparam int ONE_SECOND_MS        = 1000;
  localparam int FIFTEEN_SECOND_MS    = 15000;
  localparam int CYCLES_PER_MS        = CLK_FREQ_HZ / 1000;
  localparam int ONE_SECOND_CYCLES    = ONE_SECOND_MS * CYCLES_PER_MS;
  localparam int FIFTEEN_SECOND_CYCLES = FIFTEEN_SECOND_MS * CYCLES_PER_MS;
  localparam int TIMER_W              = 32;

  // ----------------------------------------------------------------
  // Indicator widths, state counts and line classes
  // ----------------------------------------------------------------
  localparam int LINE_STATES = 16;
  localparam int BUF_STATES  = 8;
  localparam int LINE_IND_W  = 4;
  localparam int BUF_IND_W   = 3;

  localparam logic [1:0] LCLASS_INTERMEDIATE = 2'h0;
  localparam logic [1:0] LCLASS_RECEIVING    = 2'h1;
  localparam logic [1:0] LCLASS_TRANSMITTING = 2'h2;

  localparam logic LAMP_OFF = 1'h0;

  // ----------------------------------------------------------------
  // Line controller states; bit position is the indicator value.
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    LS_IDLE_WAIT        = 16'h0001,
    LS_ATTENTION        = 16'h0002,
    LS_POLL_SEEN        = 16'h0004,
    LS_ADDRESS_WAIT     = 16'h0008,
    LS_STATUS_CHECK     = 16'h0010,
    LS_ONE_SECOND_DELAY = 16'h0020,
    LS_RECEIVE_DONE     = 16'h0040,
    LS_REPLY_SENT       = 16'h0080,
    LS_RECEIVE_MESSAGE  = 16'h0100,
    LS_PRE_RECEIVE      = 16'h0200,
    LS_TX_READY         = 16'h0400,
    LS_TX_START         = 16'h0800,
    LS_TX_WAIT          = 16'h1000,
    LS_TRANSMIT_MESSAGE = 16'h2000,
    LS_RETRY_PENDING    = 16'h4000,
    LS_FAILURE          = 16'h8000
  } lbsm_line_state_t;

  // ----------------------------------------------------------------
  // Buffer controller states; bit position is the indicator value.
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    BS_INITIAL     = 8'h01,
    BS_ENTRY       = 8'h02,
    BS_STORE       = 8'h04,
    BS_LOAD        = 8'h08,
    BS_READY       = 8'h10,
    BS_PRINT_FIRST = 8'h20,
    BS_PRINT_WAIT  = 8'h40,
    BS_PRINT_LAST  = 8'h80
  } lbsm_buf_state_t;

endpackage

// File: design/lbsm_delay_timer.sv
// Restartable one-shot delay timer with a one-cycle expiry pulse.
`timescale 1ns/1ps
`default_nettype none
module lbsm_delay_timer
  import lbsm_pkg::*;
#(
  parameter int COUNT = ONE_SECOND_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      expired
);

  logic [TIMER_W-1:0] cnt_q;

  // Start reloads the count; expiry pulses COUNT cycles after the start edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      expired <= 1'h0;
    end else begin
      expired <= 1'h0;
      if (start) begin
        cnt_q <= TIMER_W'(COUNT);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - TIMER_W'(1);
        if (cnt_q == TIMER_W'(1)) begin
          expired <= 1'h1;
        end
      end
    end
  end

  assign busy = (cnt_q != '0);

endmodule
`default_nettype wire

// File: testbench/lbsm_remote_cpu.sv
// Remote processor model that sends line characters to the terminal.
`timescale 1ns/1ps
`default_nettype none
module lbsm_remote_cpu (
  input  wire logic       clk,
  output logic            rx_char_valid,
  output logic            rx_parity_error,
  output logic [6:0]      rx_kind
);
  initial begin
    rx_char_valid = 1'h0;
    rx_parity_error = 1'h0;
    rx_kind = 7'h00;
  end

  // Qualifiers are inverted outside a character so stale values never pass.
  task automatic send(input logic [6:0] kind, input logic bad_parity);
    rx_kind = kind;
    rx_parity_error = bad_parity;
    rx_char_valid = 1'h1;
    @(posedge clk);
    #1;
    rx_char_valid = 1'h0;
    rx_kind = ~kind;
    rx_parity_error = ~bad_parity;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the line and buffer state monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lbsm_pkg::*;
  localparam int ONE_P = 20;
  localparam int FIF_P = 50;
  logic       clk = 1'h0, rst = 1'h1, group_master = 1'h0, receive_ready = 1'h1;
  logic       tx_char_done = 1'h0, tx_parity_error = 1'h0, tx_last_char = 1'h0;
  logic       kbd_strobe = 1'h0, kbd_parity_error = 1'h0, buffer_parity_error = 1'h0;
  logic       enter_key = 1'h0, send_key = 1'h0, clear_key = 1'h0, print_key = 1'h0;
  logic       reset_key = 1'h0, print_feedback_open = 1'h0, print_last_char = 1'h0;
  logic       all_stations_master = 1'h0;
  logic       rx_char_valid, rx_parity_error, transmit_enable, address_match;
  logic       receive_status, data_check_lamp, attention_lamp, first_transmission;
  logic       second_transmission, first_char_parity_fault, receive_error_flag;
  logic       rx_message_ok, rx_message_bad, print_char_strobe;
  logic [6:0] k;
  logic [3:0] line_indicator;
  logic [2:0] buffer_indicator;
  logic [1:0] line_class;
  int         num_errors = 0;
  int         checks_done = 0;
  int         n;

  always #5 clk = ~clk;

  lbsm_remote_cpu cpu_u (.clk, .rx_char_valid, .rx_parity_error, .rx_kind(k));

  lbsm_line_buffer_monitor #(.ONE_SECOND_CYCLES_P(ONE_P), .FIFTEEN_SECOND_CYCLES_P(FIF_P)) dut_u (
    .clk, .rst, .rx_char_valid, .rx_parity_error, .rx_is_poll(k[0]), .rx_is_own_address(k[1]),
    .rx_is_start(k[2]), .rx_is_end(k[3]), .rx_is_ack(k[4]), .rx_is_nak(k[5]), .rx_is_idle(k[6]),
    .tx_char_done, .tx_parity_error, .tx_last_char, .group_master, .all_stations_master,
    .receive_ready, .kbd_strobe, .kbd_parity_error, .buffer_parity_error, .enter_key, .send_key,
    .clear_key, .print_key, .print_feedback_open, .print_last_char, .reset_key, .line_indicator,
    .buffer_indicator, .line_class, .transmit_enable, .address_match, .receive_status,
    .data_check_lamp, .attention_lamp, .first_transmission, .second_transmission,
    .first_char_parity_fault, .receive_error_flag, .rx_message_ok, .rx_message_bad,
    .print_char_strobe);

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic pls(ref logic s);
    s = 1'h1;
    step();
    s = 1'h0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("unexpected at %0t: count %0d", $time, got);
    end
  endtask

  task automatic wt(input logic [3:0] idx);
    n = 0;
    while (line_indicator !== idx && n < 500) begin
      step();
      n++;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (10) step();
    rst = 1'h0;
    chk({data_check_lamp, line_indicator}, 8'h00);
    wt(4'h5);
    chk_rng(n, FIF_P, FIF_P + 2);
    wt(4'h1);
    chk_rng(n, ONE_P - 1, ONE_P + 1);
    step();
    chk(attention_lamp, 8'h01);
    cpu_u.send(7'h40, 1'h0);
    pls(reset_key);
    step();
    chk({attention_lamp, receive_status}, 8'h01);
    cpu_u.send(7'h01, 1'h0);
    cpu_u.send(7'h02, 1'h0);
    step();
    chk({line_class, line_indicator}, 8'h19);
    chk(address_match, 8'h00);
    cpu_u.send(7'h04, 1'h0);
    cpu_u.send(7'h00, 1'h1);
    chk({data_check_lamp, first_char_parity_fault}, 8'h03);
    cpu_u.send(7'h08, 1'h0);
    step();
    chk({rx_message_ok, rx_message_bad, receive_error_flag}, 8'h03);
    all_stations_master = 1'h1;
    cpu_u.send(7'h01, 1'h0);
    cpu_u.send(7'h00, 1'h0);
    all_stations_master = 1'h0;
    step();
    cpu_u.send(7'h04, 1'h0);
    cpu_u.send(7'h00, 1'h0);
    cpu_u.send(7'h08, 1'h0);
    step();
    chk({rx_message_ok, rx_message_bad, receive_error_flag, buffer_indicator}, 8'h25);
    print_feedback_open = 1'h1;
    print_last_char = 1'h1;
    step();
    chk({print_char_strobe, buffer_indicator}, 8'h0E);
    step();
    step();
    chk({receive_status, buffer_indicator}, 8'h08);
    print_feedback_open = 1'h0;
    print_last_char = 1'h0;
    receive_ready = 1'h0;
    step();
    chk(receive_status, 8'h00);
    receive_ready = 1'h1;
    pls(reset_key);
    pls(enter_key);
    chk(data_check_lamp, 8'h00);
    kbd_parity_error = 1'h1;
    pls(kbd_strobe);
    kbd_parity_error = 1'h0;
    chk(data_check_lamp, 8'h01);
    pls(reset_key);
    pls(send_key);
    chk({receive_status, buffer_indicator}, 8'h04);
    group_master = 1'h1;
    cpu_u.send(7'h01, 1'h0);
    cpu_u.send(7'h00, 1'h0);
    step();
    chk({buffer_indicator, line_indicator}, 8'h0D);
    chk({transmit_enable, first_transmission, second_transmission}, 8'h06);
    chk(line_class, LCLASS_TRANSMITTING);
    tx_parity_error = 1'h1;
    tx_last_char = 1'h1;
    pls(tx_char_done);
    chk({data_check_lamp, line_indicator}, 8'h1E);
    tx_parity_error = 1'h0;
    pls(reset_key);
    step();
    chk({data_check_lamp, line_indicator}, 8'h0E);
    cpu_u.send(7'h20, 1'h0);
    chk({second_transmission, line_indicator}, 8'h1D);
    pls(tx_char_done);
    cpu_u.send(7'h20, 1'h0);
    chk({data_check_lamp, line_indicator}, 8'h1F);
    pls(reset_key);
    group_master = 1'h0;
    chk(line_indicator, 8'h00);
    pls(enter_key);
    pls(send_key);
    pls(print_key);
    step();
    pls(buffer_parity_error);
    chk({data_check_lamp, buffer_indicator}, 8'h0E);
    print_feedback_open = 1'h1;
    print_last_char = 1'h1;
    step();
    chk(buffer_indicator, 8'h07);
    step();
    chk(buffer_indicator, 8'h04);
    complete_run();
  end
endmodule
`default_nettype wire
